// ==== hw/gpc_port.sv ====
// Sixteen-pin general purpose port with two programmable clock outputs
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
//
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module gpc_port
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [15:0] pin_in,
    output logic [15:0] pin_out,
    output logic [15:0] pin_oe,
    input wire logic [15:0] alt_out,
    input wire logic [15:0] alt_oe,
    output logic [15:0] alt_in,
    output logic irq
);
    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [15:0] dir, next_dir;
    logic [15:0] out_val, next_out_val;
    logic [12:0] irq_en, next_irq_en;
    logic [12:0] irq_type, next_irq_type;
    logic [12:0] status, next_status;
    logic [12:0] mask, next_mask;
    logic [15:0] alt_sel, next_alt_sel;
    logic [1:0] clk_sel, next_clk_sel;
    logic [15:0] clk_cfg [2];
    logic [15:0] next_clk_cfg [2];
    logic [15:0] sync1, sync2, sync3;
    logic aw_held, next_aw_held;
    logic w_held, next_w_held;
    logic [7:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic bvalid, next_bvalid;
    logic [1:0] bresp, next_bresp;
    logic rvalid, next_rvalid;
    logic [31:0] rdata, next_rdata;
    logic [1:0] rresp, next_rresp;
    logic [7:0] cnt [2];
    logic [7:0] next_cnt [2];
    logic [1:0] clk_q, next_clk_q;
    logic do_write;
    logic [31:0] wmask;
    logic [12:0] edge_hit;
    localparam int CLK_BASE = gpc_pkg::NPINS - gpc_pkg::CLK_PINS;

    // ------------------------------------------------------------------
    // Input synchroniser
    // ------------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        sync1 <= pin_in;
        sync2 <= sync1;
        sync3 <= sync2;
    end

    // ------------------------------------------------------------------
    // Interrupt detect: level high or rising edge per pin, pins 0 to 12 only
    // ------------------------------------------------------------------
    always_comb
    begin
        for (int i = 0; i < gpc_pkg::NIRQ; i++)
        begin
            edge_hit[i] = irq_en[i] && !dir[i] && !alt_sel[i] &&
                (irq_type[i] ? (sync2[i] && !sync3[i]) : sync2[i]);
        end
    end
    assign irq = |(status & mask);

    // ------------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------------
    assign s_axi_awready = !aw_held && !bvalid;
    assign s_axi_wready = !w_held && !bvalid;
    assign s_axi_arready = !rvalid;
    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp = bresp;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rdata = rdata;
    assign s_axi_rresp = rresp;
    assign do_write = aw_held && w_held && !bvalid;
    always_comb
    begin
        for (int b = 0; b < 4; b++)
        begin
            wmask[8*b +: 8] = {8{w_strb[b]}};
        end
    end

    always_comb
    begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        next_dir = dir;
        next_out_val = out_val;
        next_irq_en = irq_en;
        next_irq_type = irq_type;
        next_mask = mask;
        next_alt_sel = alt_sel;
        next_clk_sel = clk_sel;
        next_clk_cfg = clk_cfg;
        next_status = status;
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (bvalid && s_axi_bready)
        begin
            next_bvalid = 1'b0;
        end
        if (do_write)
        begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = gpc_pkg::RESP_OKAY;
            case ({aw_addr[7:2], 2'b00})
                gpc_pkg::ADDR_DIR:
                    next_dir = (dir & ~wmask[15:0]) |
                        (w_data[15:0] & wmask[15:0]);
                gpc_pkg::ADDR_OUT:
                    next_out_val = (out_val & ~wmask[15:0]) |
                        (w_data[15:0] & wmask[15:0]);
                gpc_pkg::ADDR_IRQ_EN:
                    next_irq_en = (irq_en & ~wmask[12:0]) |
                        (w_data[12:0] & wmask[12:0]);
                gpc_pkg::ADDR_IRQ_TYPE:
                    next_irq_type = (irq_type & ~wmask[12:0]) |
                        (w_data[12:0] & wmask[12:0]);
                gpc_pkg::ADDR_STATUS:
                    next_status = status & ~(w_data[12:0] & wmask[12:0]);
                gpc_pkg::ADDR_MASK:
                    next_mask = (mask & ~wmask[12:0]) |
                        (w_data[12:0] & wmask[12:0]);
                gpc_pkg::ADDR_ALT:
                    next_alt_sel = (alt_sel & ~wmask[15:0]) |
                        (w_data[15:0] & wmask[15:0]);
                gpc_pkg::ADDR_CLK_SEL:
                    if (w_strb[0])
                    begin
                        next_clk_sel = w_data[1:0];
                    end
                gpc_pkg::ADDR_CLK0:
                    next_clk_cfg[0] = (clk_cfg[0] & ~wmask[15:0]) |
                        (w_data[15:0] & wmask[15:0]);
                gpc_pkg::ADDR_CLK1:
                    next_clk_cfg[1] = (clk_cfg[1] & ~wmask[15:0]) |
                        (w_data[15:0] & wmask[15:0]);
                default:
                    next_bresp = gpc_pkg::RESP_SLVERR;
            endcase
        end
        // Set wins over a clear in the same cycle
        next_status = next_status | edge_hit;
        if (rvalid && s_axi_rready)
        begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_rvalid = 1'b1;
            next_rresp = gpc_pkg::RESP_OKAY;
            next_rdata = 32'h0000_0000;
            case ({s_axi_araddr[7:2], 2'b00})
                gpc_pkg::ADDR_DIR: next_rdata[15:0] = dir;
                gpc_pkg::ADDR_OUT: next_rdata[15:0] = out_val;
                gpc_pkg::ADDR_IN: next_rdata[15:0] = sync2;
                gpc_pkg::ADDR_IRQ_EN: next_rdata[12:0] = irq_en;
                gpc_pkg::ADDR_IRQ_TYPE: next_rdata[12:0] = irq_type;
                gpc_pkg::ADDR_STATUS: next_rdata[12:0] = status;
                gpc_pkg::ADDR_MASK: next_rdata[12:0] = mask;
                gpc_pkg::ADDR_ALT: next_rdata[15:0] = alt_sel;
                gpc_pkg::ADDR_CLK_SEL: next_rdata[1:0] = clk_sel;
                gpc_pkg::ADDR_CLK0: next_rdata[15:0] = clk_cfg[0];
                gpc_pkg::ADDR_CLK1: next_rdata[15:0] = clk_cfg[1];
                default: next_rresp = gpc_pkg::RESP_SLVERR;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Clock generators for pins 14 and 15
    // ------------------------------------------------------------------
    always_comb
    begin
        for (int k = 0; k < gpc_pkg::CLK_PINS; k++)
        begin
            logic [7:0] per;
            logic [7:0] high;
            per = clk_cfg[k][gpc_pkg::PER_LSB +: gpc_pkg::CFG_W];
            high = clk_cfg[k][gpc_pkg::HIGH_LSB +: gpc_pkg::CFG_W];
            // Period floored so the output never exceeds the top rate
            if (per < 8'(gpc_pkg::MIN_PER))
            begin
                per = 8'(gpc_pkg::MIN_PER);
            end
            if (cnt[k] < per - 8'h01)
            begin
                next_cnt[k] = cnt[k] + 8'h01;
            end
            else
            begin
                next_cnt[k] = 8'h00;
            end
            next_clk_q[k] = (next_cnt[k] < high);
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            dir <= gpc_pkg::DIR_RST;
            out_val <= '0;
            irq_en <= '0;
            irq_type <= '0;
            status <= '0;
            mask <= '0;
            alt_sel <= '0;
            clk_sel <= gpc_pkg::CLK_SEL_RST;
            clk_cfg[0] <= {gpc_pkg::HIGH_RST, gpc_pkg::PER_RST};
            clk_cfg[1] <= {gpc_pkg::HIGH_RST, gpc_pkg::PER_RST};
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            bvalid <= 1'b0;
            bresp <= gpc_pkg::RESP_OKAY;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= gpc_pkg::RESP_OKAY;
        end
        else
        begin
            dir <= next_dir;
            out_val <= next_out_val;
            irq_en <= next_irq_en;
            irq_type <= next_irq_type;
            status <= next_status;
            mask <= next_mask;
            alt_sel <= next_alt_sel;
            clk_sel <= next_clk_sel;
            clk_cfg <= next_clk_cfg;
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end

    // Clock counters run through reset so pin 15 toggles during it
    always_ff @(posedge aclk)
    begin
        cnt <= next_cnt;
        clk_q <= next_clk_q;
    end

    // ------------------------------------------------------------------
    // Pin drive: clock, alternate function or port
    // ------------------------------------------------------------------
    assign alt_in = sync2 & alt_sel;
    always_comb
    begin
        for (int p = 0; p < gpc_pkg::NPINS; p++)
        begin
            if (alt_sel[p])
            begin
                pin_out[p] = alt_out[p];
                pin_oe[p] = alt_oe[p];
            end
            else
            begin
                pin_out[p] = out_val[p];
                pin_oe[p] = dir[p];
            end
        end
        for (int k = 0; k < gpc_pkg::CLK_PINS; k++)
        begin
            if (clk_sel[k])
            begin
                pin_out[CLK_BASE + k] = clk_q[k];
                pin_oe[CLK_BASE + k] = dir[CLK_BASE + k];
            end
        end
    end
endmodule

// ==== hw/gpc_pkg.sv ====
// Package: register map, field layout, reset values and timing for the port
package gpc_pkg;
    localparam int NPINS = 16;
    localparam int NIRQ = 13;
    localparam int CLK_PINS = 2;
    // Register byte offsets
    localparam logic [7:0] ADDR_DIR = 8'h00;
    localparam logic [7:0] ADDR_OUT = 8'h04;
    localparam logic [7:0] ADDR_IN = 8'h08;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_TYPE = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    localparam logic [7:0] ADDR_MASK = 8'h18;
    localparam logic [7:0] ADDR_ALT = 8'h1C;
    localparam logic [7:0] ADDR_CLK_SEL = 8'h20;
    localparam logic [7:0] ADDR_CLK0 = 8'h24;
    localparam logic [7:0] ADDR_CLK1 = 8'h28;
    // Direction: 1 = output. Pin 15 leaves reset as an output
    localparam logic [15:0] DIR_RST = 16'h8000;
    // Clock-select: pin 15 starts in clock mode
    localparam logic [1:0] CLK_SEL_RST = 2'h2;
    // Clock config fields: period [7:0], high time [15:8]
    localparam int PER_LSB = 0;
    localparam int HIGH_LSB = 8;
    localparam int CFG_W = 8;
    // Maximum output clock and least period in system cycles
    localparam int SYS_MHZ = 250;
    localparam int MAX_CLK_MHZ = 33;
    localparam int MIN_PER = (SYS_MHZ + MAX_CLK_MHZ - 1) / MAX_CLK_MHZ;
    // Reset clock: period 8 (31.25 MHz), high 4 (50 %)
    localparam logic [7:0] PER_RST = 8'h08;
    localparam logic [7:0] HIGH_RST = 8'h04;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== bench/gpc_pin_model.sv ====
// Board side of the port pins: external drivers
`timescale 1ns/1ps
module gpc_pin_model
(
    input wire logic [15:0] ext,
    input wire logic [15:0] pin_out,
    input wire logic [15:0] pin_oe,
    output logic [15:0] pin_in
);
    // ------------------------------------------------
    // Pin level: port drive wins, else board level
    // ------------------------------------------------
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule

// ==== bench/gpc_port_props.sv ====
// Checker of bus handshakes, reset state and pin 15 clock
`timescale 1ns/1ps
module gpc_port_props
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [15:0] pin_out,
    input wire logic [15:0] pin_oe
);
    // ------------------------------------------------
    // Properties
    // ------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_clk_rise;
        $rose(pin_out[15]) && pin_oe[15];
    endsequence
    a_rst_dir: assert property ($past(!aresetn) |-> pin_oe == 16'h8000)
        else $error("pin enables wrong after reset");
    a_w_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
        else $error("write response missing");
    a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write address taken during response");
    a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data missing");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken during response");
    a_clk_space: assert property (s_clk_rise |=> !$rose(pin_out[15]) [*7])
        else $error("pin 15 clock faster than limit");
endmodule
bind gpc_port gpc_port_props props_u (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .pin_out, .pin_oe);

// ==== bench/tb_gpc_port.sv ====
// Testbench of the general purpose port
`timescale 1ns/1ps
module tb_gpc_port;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [15:0] pin_in, pin_out, pin_oe, alt_in;
    logic [15:0] ext = 16'hffff;
    logic [15:0] alt_out = 16'h0000;
    logic [15:0] alt_oe = 16'h0000;
    int errors = 0;
    int n_tests = 0;
    logic [1:0] wresp = 2'h0;
    always #2 aclk = ~aclk;
    gpc_port dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out,
        .pin_oe, .alt_out, .alt_oe, .alt_in, .irq);
    gpc_pin_model pm_u (.ext, .pin_out, .pin_oe, .pin_in);
    // ------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------
    task automatic summarize;
        $display("Checks %0d, errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic hang;
        errors++;
        $display("Error at %0t: bus wait ran out", $time);
        summarize;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            n++;
        end
        while (!s_axi_bvalid && n < 50);
        if (n == 50)
            hang;
        wresp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
        output logic [1:0] r);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && !s_axi_rready)
                s_axi_rready <= 1'b1;
            n++;
        end
        while (!(s_axi_rvalid && s_axi_rready) && n < 50);
        if (n == 50)
            hang;
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(d, e);
        chk(r, gpc_pkg::RESP_OKAY);
    endtask
    task automatic rises(input int b, input int cyc, output int r,
        output int h);
        logic p;
        r = 0;
        h = 0;
        p = pin_out[b];
        repeat (cyc)
        begin
            @(posedge aclk);
            r += int'(pin_out[b] && !p);
            h += int'(pin_out[b]);
            p = pin_out[b];
        end
    endtask
    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial
    begin
        logic [31:0] d;
        logic [1:0] r;
        int nr, nh;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        chk(pin_oe, 32'h0000_8000);
        rchk(gpc_pkg::ADDR_DIR, 32'h0000_8000);
        rchk(gpc_pkg::ADDR_CLK_SEL, 32'h0000_0002);
        repeat (256) @(posedge aclk);
        rises(15, 64, nr, nh);
        chk(nr, 8);
        chk(nh, 32);
        wr(gpc_pkg::ADDR_DIR, 32'h0000_00ff);
        chk(wresp, gpc_pkg::RESP_OKAY);
        wr(gpc_pkg::ADDR_OUT, 32'h0000_a5a5);
        ext <= 16'h1234;
        repeat (4) @(posedge aclk);
        chk(pin_oe, 32'h0000_00ff);
        chk(pin_out & pin_oe, 32'h0000_00a5);
        rchk(gpc_pkg::ADDR_IN, 32'h0000_12a5);
        ext <= 16'h0000;
        wr(gpc_pkg::ADDR_IRQ_TYPE, 32'h0000_0400);
        wr(gpc_pkg::ADDR_MASK, 32'h0000_2600);
        wr(gpc_pkg::ADDR_IRQ_EN, 32'h0000_2600);
        wr(gpc_pkg::ADDR_STATUS, 32'h0000_ffff);
        chk(irq, 32'h0000_0000);
        ext <= 16'h2600;
        repeat (5) @(posedge aclk);
        chk(irq, 32'h0000_0001);
        rchk(gpc_pkg::ADDR_STATUS, 32'h0000_0600);
        wr(gpc_pkg::ADDR_MASK, 32'h0000_0000);
        chk(irq, 32'h0000_0000);
        wr(gpc_pkg::ADDR_STATUS, 32'h0000_0600);
        rchk(gpc_pkg::ADDR_STATUS, 32'h0000_0200);
        ext <= 16'h0000;
        repeat (5) @(posedge aclk);
        wr(gpc_pkg::ADDR_STATUS, 32'h0000_0200);
        rchk(gpc_pkg::ADDR_STATUS, 32'h0000_0000);
        wr(gpc_pkg::ADDR_DIR, 32'h0000_40ff);
        wr(gpc_pkg::ADDR_CLK_SEL, 32'h0000_0001);
        wr(gpc_pkg::ADDR_CLK0, 32'h0000_0410);
        repeat (40) @(posedge aclk);
        rises(14, 160, nr, nh);
        chk(nr, 10);
        chk(nh, 40);
        wr(gpc_pkg::ADDR_CLK0, 32'h0000_0102);
        repeat (40) @(posedge aclk);
        rises(14, 64, nr, nh);
        chk(nr, 8);
        chk(nh, 8);
        wr(gpc_pkg::ADDR_CLK_SEL, 32'h0000_0000);
        wr(gpc_pkg::ADDR_OUT, 32'h0000_4000);
        chk(pin_out[14], 32'h0000_0001);
        alt_out <= 16'h0001;
        alt_oe <= 16'h0001;
        wr(gpc_pkg::ADDR_DIR, 32'h0000_0000);
        wr(gpc_pkg::ADDR_ALT, 32'h0000_0001);
        repeat (4) @(posedge aclk);
        chk(pin_oe, 32'h0000_0001);
        chk(alt_in, 32'h0000_0001);
        rd(8'h40, d, r);
        chk(r, gpc_pkg::RESP_SLVERR);
        chk(d, 32'h0000_0000);
        wr(8'h40, 32'h0000_0001);
        chk(wresp, gpc_pkg::RESP_SLVERR);
        summarize;
    end
endmodule
